// *** rtl/ssxalu_core.sv ***
// Execution datapath for subtract, swap, direction load and xor operations
`default_nettype none
module ssxalu_core
  import ssxalu_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Instruction from decoder
  input wire logic op_valid,
  input wire ssxalu_op_t op_sel,
  input wire logic [7:0] literal,
  input wire logic [6:0] file_addr,
  input wire logic dest_sel,
  // File register read data for file_addr
  input wire logic [7:0] file_rdata,
  // File register write-back
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  // Architectural state
  output logic [7:0] w_out,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] w_reg, w_next;
  logic c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
  logic [7:0] dir_reg [3];
  logic [7:0] dir_next [3];
  logic fwe_reg, fwe_next;
  logic [6:0] fwa_reg, fwa_next;
  logic [7:0] fwd_reg, fwd_next;
  logic [7:0] sub_a, sub_diff, result;
  logic sub_cin, sub_c, sub_dc;
  logic to_dest, upd_z, upd_cdc;

  // Literal ops use the literal as minuend, file ops the file register
  ssxalu_sub u_sub (
    .minuend(sub_a),
    .subtrahend(w_reg),
    .carry_in(sub_cin),
    .diff(sub_diff),
    .carry_out(sub_c),
    .digit_carry_out(sub_dc)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sub_a = file_rdata;
    sub_cin = 1'b1;
    result = 8'h00;
    to_dest = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    case (op_sel)
      SSX_OP_SUB_LIT: begin
        sub_a = literal;
        result = sub_diff;
        upd_z = 1'b1;
        upd_cdc = 1'b1;
      end
      SSX_OP_SUB_FILE: begin
        result = sub_diff;
        to_dest = 1'b1;
        upd_z = 1'b1;
        upd_cdc = 1'b1;
      end
      SSX_OP_SUB_BORROW: begin
        sub_cin = c_reg;
        result = sub_diff;
        to_dest = 1'b1;
        upd_z = 1'b1;
        upd_cdc = 1'b1;
      end
      SSX_OP_SWAP: begin
        result = {file_rdata[SSX_NIB_LO:0], file_rdata[SSX_NIB_HI:4]};
        to_dest = 1'b1;
      end
      SSX_OP_XOR_LIT: begin
        result = w_reg ^ literal;
        upd_z = 1'b1;
      end
      SSX_OP_XOR_FILE: begin
        result = w_reg ^ file_rdata;
        to_dest = 1'b1;
        upd_z = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    w_next = w_reg;
    c_next = c_reg;
    dc_next = dc_reg;
    z_next = z_reg;
    fwe_next = 1'b0;
    fwa_next = fwa_reg;
    fwd_next = fwd_reg;
    for (int i = 0; i < 3; i++) begin
      dir_next[i] = dir_reg[i];
    end
    if (op_valid) begin
      if (op_sel == SSX_OP_LOAD_DIR) begin
        if (file_addr[2:0] == SSX_DIR_A_SEL && file_addr[6:3] == 4'h0) begin
          dir_next[0] = w_reg;
        end else if (file_addr == {4'h0, SSX_DIR_B_SEL}) begin
          dir_next[1] = w_reg;
        end else if (file_addr == {4'h0, SSX_DIR_C_SEL}) begin
          dir_next[2] = w_reg;
        end
      end else if (op_sel != SSX_OP_NONE) begin
        if (to_dest && dest_sel != SSX_DEST_W) begin
          fwe_next = 1'b1;
          fwa_next = file_addr;
          fwd_next = result;
        end else begin
          w_next = result;
        end
        if (upd_cdc) begin
          c_next = sub_c;
          dc_next = sub_dc;
        end
        if (upd_z) begin
          z_next = (result == 8'h00);
        end
      end
    end
  end

  // Direction registers reset to all inputs, the safe pin state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_reg <= SSX_W_RESET;
      c_reg <= SSX_FLAG_RESET;
      dc_reg <= SSX_FLAG_RESET;
      z_reg <= SSX_FLAG_RESET;
      fwe_reg <= 1'b0;
      fwa_reg <= 7'h00;
      fwd_reg <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        dir_reg[i] <= SSX_DIR_RESET;
      end
    end else if (clk_en) begin
      w_reg <= w_next;
      c_reg <= c_next;
      dc_reg <= dc_next;
      z_reg <= z_next;
      fwe_reg <= fwe_next;
      fwa_reg <= fwa_next;
      fwd_reg <= fwd_next;
      for (int i = 0; i < 3; i++) begin
        dir_reg[i] <= dir_next[i];
      end
    end
  end

  assign w_out = w_reg;
  assign carry_flag = c_reg;
  assign digit_carry_flag = dc_reg;
  assign zero_flag = z_reg;
  assign file_we = fwe_reg;
  assign file_waddr = fwa_reg;
  assign file_wdata = fwd_reg;
  assign port_a_direction = dir_reg[0];
  assign port_b_direction = dir_reg[1];
  assign port_c_direction = dir_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  logic go;
  assign go = clk_en && op_valid;

  chk_sub_lit_value: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_SUB_LIT |=> w_reg == $past(literal) - $past(w_reg))
    else $error("literal subtract result wrong");
  chk_sub_lit_carry: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_SUB_LIT |=> c_reg == ($past(w_reg) <= $past(literal))
      && dc_reg == ($past(w_reg[3:0]) <= $past(literal[3:0])))
    else $error("literal subtract carry wrong");
  chk_sub_file_dest: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_SUB_FILE && dest_sel |=> file_we
      && file_wdata == $past(file_rdata) - $past(w_reg)
      && c_reg == ($past(w_reg) <= $past(file_rdata)))
    else $error("file subtract result wrong");
  chk_sub_borrow: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_SUB_BORROW && !dest_sel |=> w_reg ==
      8'($past(file_rdata) - $past(w_reg) - {7'h00, !$past(c_reg)}))
    else $error("borrow subtract result wrong");
  chk_swap_flags: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_SWAP && !dest_sel |=> $stable({c_reg, dc_reg, z_reg})
      && w_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap wrong");
  chk_dir_load: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_LOAD_DIR && file_addr == 7'h06
      |=> dir_reg[1] == $past(w_reg) && $stable(dir_reg[0]) && $stable(z_reg))
    else $error("direction load wrong");
  chk_xor_lit: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_XOR_LIT |=> w_reg == ($past(w_reg) ^ $past(literal))
      && $stable(c_reg) && $stable(dc_reg))
    else $error("literal xor wrong");
  chk_xor_file: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_XOR_FILE && dest_sel |=> file_we
      && file_wdata == ($past(w_reg) ^ $past(file_rdata)) && $stable(w_reg))
    else $error("file xor wrong");
  chk_dest_w: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_XOR_FILE && !dest_sel |=> !file_we)
    else $error("write-back with working destination");
  chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    go && op_sel == SSX_OP_XOR_LIT |=> zero_flag == (w_reg == 8'h00))
    else $error("zero flag wrong");
endmodule : ssxalu_core
`default_nettype wire

// *** rtl/ssxalu_pkg.sv ***
// Package for the subtract/swap/xor execution datapath
`default_nettype none
package ssxalu_pkg;
  // Operation select codes, one-hot
  typedef enum logic [7:0] {
    SSX_OP_NONE = 8'h01,
    SSX_OP_SUB_LIT = 8'h02,
    SSX_OP_SUB_FILE = 8'h04,
    SSX_OP_SUB_BORROW = 8'h08,
    SSX_OP_SWAP = 8'h10,
    SSX_OP_LOAD_DIR = 8'h20,
    SSX_OP_XOR_LIT = 8'h40,
    SSX_OP_XOR_FILE = 8'h80
  } ssxalu_op_t;
  localparam int SSX_DATA_W = 8;
  localparam int SSX_ADDR_W = 7;
  localparam int SSX_NIB_HI = 7;
  localparam int SSX_NIB_LO = 3;
  localparam logic [2:0] SSX_DIR_A_SEL = 3'h5;
  localparam logic [2:0] SSX_DIR_B_SEL = 3'h6;
  localparam logic [2:0] SSX_DIR_C_SEL = 3'h7;
  localparam logic [7:0] SSX_W_RESET = 8'h00;
  localparam logic [7:0] SSX_DIR_RESET = 8'hFF;
  localparam logic SSX_FLAG_RESET = 1'b0;
  localparam logic SSX_DEST_W = 1'b0;
endpackage : ssxalu_pkg
`default_nettype wire

// *** rtl/ssxalu_sub.sv ***
// Eight-bit subtractor with no-borrow carry and digit carry
`default_nettype none
module ssxalu_sub
  import ssxalu_pkg::*;
(
  // Operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic carry_in,
  // Results
  output logic [7:0] diff,
  output logic carry_out,
  output logic digit_carry_out
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  // Two's complement: a + ~b + c, carry out high means no borrow
  always_comb begin
    low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
      + {4'h0, carry_in};
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    diff = full_sum[7:0];
    carry_out = full_sum[8];
    digit_carry_out = low_sum[4];
  end
endmodule : ssxalu_sub
`default_nettype wire

// *** sim/ssxalu_mem.sv ***
// File register memory standing behind the datapath
`default_nettype none
module ssxalu_mem (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic [6:0] raddr,
  output logic [7:0] rdata,
  // Write port
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[waddr] <= wdata;
    end
  end
  // Pending write is forwarded so a back-to-back read sees it
  assign rdata = (we === 1'b1 && waddr == raddr) ? wdata : mem[raddr];
endmodule // ssxalu_mem
`default_nettype wire

// *** sim/tb_sub_swap_xor_alu_ops.sv ***
// Self-checking bench for the subtract, swap and xor datapath
`default_nettype none
module tb_sub_swap_xor_alu_ops import ssxalu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b0;
  logic op_valid = 1'b0;
  ssxalu_op_t op_sel = SSX_OP_NONE;
  logic [7:0] literal = 8'h00;
  logic [6:0] file_addr = 7'h00;
  logic dest_sel = 1'b0;
  logic [7:0] file_rdata, w_out, pa, pb, pc, file_wdata;
  logic file_we, cf, dcf, zf;
  logic [6:0] file_waddr;
  int mismatches = 0;
  int samples_checked = 0;
  logic [50:0] exp_q [$];
  logic [50:0] got;
  logic [7:0] mref [128];
  logic [7:0] rw, rda, rdb, rdd, rwd;
  logic rc, rdc, rz, rwe;
  logic [6:0] rwa;

  always #20 clk = ~clk;

  ssxalu_core u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .op_valid(op_valid), .op_sel(op_sel), .literal(literal),
    .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .w_out(w_out), .carry_flag(cf), .digit_carry_flag(dcf),
    .zero_flag(zf), .port_a_direction(pa), .port_b_direction(pb),
    .port_c_direction(pc));
  ssxalu_mem u_mem (.clk(clk), .raddr(file_addr), .rdata(file_rdata),
    .we(file_we), .waddr(file_waddr), .wdata(file_wdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic step(input ssxalu_op_t op, input logic [7:0] k,
    input logic [6:0] fa, input logic d, input logic v, input logic en);
    logic [7:0] fv, m, r;
    logic [8:0] s;
    logic [4:0] n;
    logic c, lit;
    @(posedge clk);
    #1;
    op_sel = op;
    literal = k;
    file_addr = fa;
    dest_sel = d;
    op_valid = v;
    clk_en = en;
    fv = mref[fa];
    m = (op == SSX_OP_SUB_LIT) ? k : fv;
    c = (op == SSX_OP_SUB_BORROW) ? rc : 1'b1;
    s = {1'b0, m} + {1'b0, ~rw} + 9'(c);
    n = {1'b0, m[3:0]} + {1'b0, ~rw[3:0]} + 5'(c);
    lit = op inside {SSX_OP_SUB_LIT, SSX_OP_XOR_LIT};
    if (en) rwe = 1'b0;
    case (op)
      SSX_OP_SUB_LIT, SSX_OP_SUB_FILE, SSX_OP_SUB_BORROW: r = s[7:0];
      SSX_OP_SWAP: r = {fv[3:0], fv[7:4]};
      SSX_OP_XOR_LIT: r = rw ^ k;
      default: r = rw ^ fv;
    endcase
    if (v && en && op == SSX_OP_LOAD_DIR) begin
      if (fa == 7'h05) rda = rw;
      if (fa == 7'h06) rdb = rw;
      if (fa == 7'h07) rdd = rw;
    end else if (v && en && op != SSX_OP_NONE) begin
      if (op inside {SSX_OP_SUB_LIT, SSX_OP_SUB_FILE, SSX_OP_SUB_BORROW})
        {rc, rdc} = {s[8], n[4]};
      if (op != SSX_OP_SWAP) rz = (r == 8'h00);
      if (lit || !d) rw = r;
      else begin
        rwe = 1'b1;
        rwa = fa;
        rwd = r;
        mref[fa] = r;
      end
    end
    exp_q.push_back({rw, rc, rdc, rz, rda, rdb, rdd, rwe, rwa, rwd});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (exp_q.size() > 0) begin
      #2;
      got = {w_out, cf, dcf, zf, pa, pb, pc, file_we, file_waddr, file_wdata};
      samples_checked++;
      if (got !== exp_q[0]) begin
        $display("unexpected t=%0t got=%h exp=%h", $time, got, exp_q[0]);
        mismatches++;
      end
      void'(exp_q.pop_front());
    end
  end

  initial begin
    #300000;
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h4a96f497));
    for (int i = 0; i < 128; i++) begin
      mref[i] = 8'($urandom);
      u_mem.mem[i] = mref[i];
    end
    {rw, rc, rdc, rz} = {SSX_W_RESET, {3{SSX_FLAG_RESET}}};
    {rda, rdb, rdd} = {3{SSX_DIR_RESET}};
    {rwe, rwa, rwd} = '0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Small address set forces read-after-write and direction hits
    for (int i = 0; i < 3000; i++) begin
      step(ssxalu_op_t'(8'h01 << $urandom_range(7)),
        ($urandom_range(3) == 0) ? rw : 8'($urandom),
        7'($urandom_range(7)) | (($urandom_range(1) == 1) ? 7'h78 : 7'h00),
        1'($urandom), $urandom_range(7) != 0, $urandom_range(7) != 0);
    end
    repeat (3) @(posedge clk);
    if (exp_q.size() > 0) mismatches++;
    complete_run();
  end
endmodule // tb_sub_swap_xor_alu_ops
`default_nettype wire
